/* hdl/bcs_pkg.sv */
// Constants, register map and state codes of the bulk capacitor switch controller.
// Assumes a 200 MHz system clock and comparator levels arriving as asynchronous pins.
// What this block does
// - Switch stays on below upper threshold.
// - Switch opens at upper threshold.
// - Reconnect below lower threshold with bottom near zero.
// - Trickle charge while bus stays above upper.
// - Hold low-voltage capacitor inside maintenance window.
// - Bulk undervoltage for 500 ms restarts.
// - Surge while on blanks switch 130 us.
// - Surges are never signalled to companion.
// - Faults reach companion only via signalling output.
// - Over-temperature shuts down, drives fault current.
// - Temperature recovery restarts normal start-up.
// - Pin faults drive fault current while present.
// - Pin fault clearing restarts normal start-up.
// - Normal operation signal tracks top sense current.
// - Power-up starts off, switch open.
// - Start-up outputs hold-off signal current.
// - Wait 20 ms, then pulse charge or enable.
package bcs_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned BROWNOUT_MS = 500;
	localparam int unsigned SETTLE_MS = 20;
	localparam int unsigned BLANK_US = 130;
	localparam int unsigned BROWNOUT_CYC = BROWNOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
	localparam int unsigned BLANK_CYC = BLANK_US * (CLK_HZ / 1000000);

	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_EVENTS = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam logic [3:0] EVENTS_RESET = 4'h0;
	localparam int EV_SURGE = 0;
	localparam int EV_THERMAL = 1;
	localparam int EV_PINFAULT = 2;
	localparam int EV_BROWNOUT = 3;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_SWITCH = 4;
	localparam int ST_TRICKLE = 5;
	localparam int ST_CHARGE = 6;
	localparam int ST_SIG_LSB = 7;
	localparam int ST_IN_LSB = 9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int N_IN = 12;
	localparam int IN_ABOVE_UPPER = 0;
	localparam int IN_BELOW_LOWER = 1;
	localparam int IN_BOTTOM_ZERO = 2;
	localparam int IN_BROWN_IN = 3;
	localparam int IN_BELOW_UV = 4;
	localparam int IN_LOW_LINE = 5;
	localparam int IN_WIN_LOW = 6;
	localparam int IN_WIN_HIGH = 7;
	localparam int IN_OVER_TEMP = 8;
	localparam int IN_TEMP_OK = 9;
	localparam int IN_PIN_FAULT = 10;
	localparam int IN_SURGE = 11;

	typedef enum logic [1:0] {
		BCS_SIG_TRACK = 2'h0,
		BCS_SIG_HOLDOFF = 2'h1,
		BCS_SIG_FAULT = 2'h2
	} bcs_sig_e;

	typedef enum logic [3:0] {
		BCS_OFF = 4'h0,
		BCS_WAIT_IN = 4'h1,
		BCS_SETTLE = 4'h2,
		BCS_CHARGE = 4'h3,
		BCS_RUN_ON = 4'h4,
		BCS_RUN_OFF = 4'h5,
		BCS_BLANK = 4'h6,
		BCS_THERMAL = 4'h7,
		BCS_PINFLT = 4'h8
	} bcs_state_e;
endpackage

/* hdl/bcs_sync.sv */
// Two-flop synchroniser bank for the comparator pins.
// Assumes every input bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module bcs_sync #(
	parameter int WIDTH = 12
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	generate
		if (WIDTH < 1)
		begin : g_chk
			$error("bcs_sync needs at least one bit");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= async_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_r;
endmodule

/* hdl/bcs_ctrl.sv */
// Steady-state, start-up sequencing and fault control of the bulk capacitor switch, with an AXI4-Lite slave.
// Assumes analog comparators present each threshold decision as a level and that line_sig_sel steers
// the current mirror on the signalling output.
`timescale 1ns/1ps
module bcs_ctrl #(
	parameter int unsigned BROWNOUT_CYCLES = bcs_pkg::BROWNOUT_CYC,
	parameter int unsigned SETTLE_CYCLES = bcs_pkg::SETTLE_CYC,
	parameter int unsigned BLANK_CYCLES = bcs_pkg::BLANK_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic bulk_above_upper,
	input wire logic bulk_below_lower,
	input wire logic bottom_near_zero,
	input wire logic bulk_brown_in,
	input wire logic bulk_below_uv,
	input wire logic bulk_low_line,
	input wire logic clv_window_low,
	input wire logic clv_window_high,
	input wire logic over_temp,
	input wire logic temp_recovered,
	input wire logic pin_fault,
	input wire logic surge_detect,
	output logic switch_on,
	output logic trickle_on,
	output logic charge_src_on,
	output bcs_pkg::bcs_sig_e line_sig_sel,
	input wire logic [bcs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bcs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import bcs_pkg::*;

	generate
		if (BROWNOUT_CYCLES < 1 || SETTLE_CYCLES < 1 || BLANK_CYCLES < 1)
		begin : g_chk
			$error("bcs_ctrl timer counts must be at least one cycle");
		end
	endgenerate

	logic [N_IN-1:0] pins;
	logic [N_IN-1:0] sin;

	assign pins[IN_ABOVE_UPPER] = bulk_above_upper;
	assign pins[IN_BELOW_LOWER] = bulk_below_lower;
	assign pins[IN_BOTTOM_ZERO] = bottom_near_zero;
	assign pins[IN_BROWN_IN] = bulk_brown_in;
	assign pins[IN_BELOW_UV] = bulk_below_uv;
	assign pins[IN_LOW_LINE] = bulk_low_line;
	assign pins[IN_WIN_LOW] = clv_window_low;
	assign pins[IN_WIN_HIGH] = clv_window_high;
	assign pins[IN_OVER_TEMP] = over_temp;
	assign pins[IN_TEMP_OK] = temp_recovered;
	assign pins[IN_PIN_FAULT] = pin_fault;
	assign pins[IN_SURGE] = surge_detect;

	bcs_sync #(
		.WIDTH(N_IN)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(pins),
		.sync_out(sin)
	);

	// Control state machine.
	bcs_state_e state_r, state_nxt;
	logic [31:0] timer_r, timer_nxt;
	logic [31:0] bo_timer_r, bo_timer_nxt;
	logic switch_r, switch_nxt;
	logic trickle_r, trickle_nxt;
	logic charge_r, charge_nxt;
	bcs_sig_e sig_r, sig_nxt;
	logic [3:0] ev_set;
	logic ctrl_en_r, ctrl_en_nxt;
	logic run_state;

	assign run_state = (state_r == BCS_RUN_ON) || (state_r == BCS_RUN_OFF) || (state_r == BCS_BLANK);

	always_comb
	begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		bo_timer_nxt = 32'h0;
		ev_set = 4'h0;
		if (sin[IN_OVER_TEMP] && state_r != BCS_THERMAL)
		begin
			state_nxt = BCS_THERMAL;
			ev_set[EV_THERMAL] = 1'b1;
		end
		else if (sin[IN_PIN_FAULT] && state_r != BCS_THERMAL && state_r != BCS_PINFLT)
		begin
			state_nxt = BCS_PINFLT;
			ev_set[EV_PINFAULT] = 1'b1;
		end
		else if (!ctrl_en_r && state_r != BCS_THERMAL && state_r != BCS_PINFLT)
		begin
			state_nxt = BCS_OFF;
		end
		else if (run_state && sin[IN_BELOW_UV] && bo_timer_r == BROWNOUT_CYCLES - 32'h1)
		begin
			state_nxt = BCS_OFF;
			ev_set[EV_BROWNOUT] = 1'b1;
		end
		else
		begin
			if (run_state && sin[IN_BELOW_UV])
			begin
				bo_timer_nxt = bo_timer_r + 32'h1;
			end
			unique case (state_r)
				BCS_OFF:
				begin
					timer_nxt = 32'h0;
					state_nxt = BCS_WAIT_IN;
				end
				BCS_WAIT_IN:
				begin
					timer_nxt = 32'h0;
					if (sin[IN_BROWN_IN])
					begin
						state_nxt = BCS_SETTLE;
					end
				end
				BCS_SETTLE:
				begin
					timer_nxt = timer_r + 32'h1;
					if (timer_r == SETTLE_CYCLES - 32'h1)
					begin
						timer_nxt = 32'h0;
						state_nxt = sin[IN_LOW_LINE] ? BCS_CHARGE : BCS_RUN_OFF;
					end
				end
				BCS_CHARGE:
				begin
					if (sin[IN_WIN_HIGH])
					begin
						state_nxt = BCS_RUN_OFF;
					end
				end
				BCS_RUN_ON:
				begin
					timer_nxt = 32'h0;
					if (sin[IN_ABOVE_UPPER])
					begin
						state_nxt = BCS_RUN_OFF;
					end
					else if (sin[IN_SURGE])
					begin
						state_nxt = BCS_BLANK;
						ev_set[EV_SURGE] = 1'b1;
					end
				end
				BCS_RUN_OFF:
				begin
					if (sin[IN_BELOW_LOWER] && sin[IN_BOTTOM_ZERO])
					begin
						state_nxt = BCS_RUN_ON;
					end
				end
				BCS_BLANK:
				begin
					timer_nxt = timer_r + 32'h1;
					if (timer_r == BLANK_CYCLES - 32'h1)
					begin
						timer_nxt = 32'h0;
						state_nxt = BCS_RUN_OFF;
					end
				end
				BCS_THERMAL:
				begin
					if (sin[IN_TEMP_OK] && !sin[IN_OVER_TEMP])
					begin
						state_nxt = BCS_OFF;
					end
				end
				BCS_PINFLT:
				begin
					if (!sin[IN_PIN_FAULT])
					begin
						state_nxt = BCS_OFF;
					end
				end
				default:
				begin
					state_nxt = BCS_OFF;
				end
			endcase
		end
	end

	// Outputs follow the state being entered so they change with the state itself.
	always_comb
	begin
		switch_nxt = (state_nxt == BCS_RUN_ON);
		charge_nxt = (state_nxt == BCS_CHARGE);
		unique case (state_nxt)
			BCS_THERMAL, BCS_PINFLT:
			begin
				sig_nxt = BCS_SIG_FAULT;
			end
			BCS_RUN_ON, BCS_RUN_OFF, BCS_BLANK:
			begin
				sig_nxt = BCS_SIG_TRACK;
			end
			default:
			begin
				sig_nxt = BCS_SIG_HOLDOFF;
			end
		endcase
		trickle_nxt = 1'b0;
		if (state_nxt == BCS_RUN_OFF && sin[IN_ABOVE_UPPER])
		begin
			if (sin[IN_WIN_LOW])
			begin
				trickle_nxt = 1'b1;
			end
			else if (sin[IN_WIN_HIGH])
			begin
				trickle_nxt = 1'b0;
			end
			else
			begin
				trickle_nxt = trickle_r;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= BCS_OFF;
			timer_r <= 32'h0;
			bo_timer_r <= 32'h0;
			switch_r <= 1'b0;
			trickle_r <= 1'b0;
			charge_r <= 1'b0;
			sig_r <= BCS_SIG_HOLDOFF;
		end
		else
		begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			bo_timer_r <= bo_timer_nxt;
			switch_r <= switch_nxt;
			trickle_r <= trickle_nxt;
			charge_r <= charge_nxt;
			sig_r <= sig_nxt;
		end
	end

	assign switch_on = switch_r;
	assign trickle_on = trickle_r;
	assign charge_src_on = charge_r;
	assign line_sig_sel = sig_r;

	// AXI4-Lite slave; address and data are captured independently, the write lands once both are held.
	logic aw_held_r, aw_held_nxt;
	logic w_held_r, w_held_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0] events_r, events_nxt;
	logic [3:0] ev_clr;
	logic [31:0] status_word;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;

	always_comb
	begin
		status_word = 32'h0;
		status_word[ST_STATE_LSB +: 4] = state_r;
		status_word[ST_SWITCH] = switch_r;
		status_word[ST_TRICKLE] = trickle_r;
		status_word[ST_CHARGE] = charge_r;
		status_word[ST_SIG_LSB +: 2] = sig_r;
		status_word[ST_IN_LSB +: N_IN] = sin;
	end

	always_comb
	begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		ctrl_en_nxt = ctrl_en_r;
		ev_clr = 4'h0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (aw_held_r && w_held_r)
		begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			unique case (awaddr_r)
				ADDR_CTRL:
				begin
					if (wstrb_r[0])
					begin
						ctrl_en_nxt = wdata_r[CTRL_EN_BIT];
					end
				end
				ADDR_STATUS:
				begin
				end
				ADDR_EVENTS:
				begin
					if (wstrb_r[0])
					begin
						ev_clr = wdata_r[3:0];
					end
				end
				default:
				begin
					bresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		else if (bvalid_r && s_axi_bready)
		begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL:
				begin
					rdata_nxt = {31'h0, ctrl_en_r};
				end
				ADDR_STATUS:
				begin
					rdata_nxt = status_word;
				end
				ADDR_EVENTS:
				begin
					rdata_nxt = {28'h0, events_r};
				end
				default:
				begin
					rdata_nxt = 32'h0;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_nxt = 1'b0;
		end
		// A new event wins over a clear that arrives in the same cycle.
		events_nxt = (events_r & ~ev_clr) | ev_set;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
			ctrl_en_r <= CTRL_EN_RESET;
			events_r <= EVENTS_RESET;
		end
		else
		begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			ctrl_en_r <= ctrl_en_nxt;
			events_r <= events_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
endmodule

/* sim/bcs_props.sv */
// Concurrent checks on the switch, trickle and signalling outputs.
// Assumes a comparator level reaches the outputs three edges after it changes.
`timescale 1ns/1ps
module bcs_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic bulk_above_upper,
	input wire logic bulk_below_lower,
	input wire logic bottom_near_zero,
	input wire logic clv_window_low,
	input wire logic over_temp,
	input wire logic pin_fault,
	input wire logic surge_detect,
	input wire logic switch_on,
	input wire logic trickle_on,
	input wire bcs_pkg::bcs_sig_e line_sig_sel
);
	import bcs_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_start_open: assert property ($rose(rst_n) |-> !switch_on && line_sig_sel == BCS_SIG_HOLDOFF)
		else $error("switch closed or wrong signal after reset");
	a_open_above: assert property (bulk_above_upper [*5] |-> !switch_on)
		else $error("switch closed above upper threshold");
	a_reconnect_cause: assert property ($rose(switch_on) |-> $past(bulk_below_lower, 3) && $past(bottom_near_zero, 3))
		else $error("switch closed without reconnect condition");
	a_track_on: assert property (switch_on |-> line_sig_sel == BCS_SIG_TRACK)
		else $error("signal not tracking while switch closed");
	a_surge_blank: assert property ($fell(switch_on) && $past(surge_detect, 3) && !$past(bulk_above_upper, 3)
		|-> !switch_on [*8])
		else $error("surge blanking too short");
	a_thermal_fault: assert property (over_temp [*5] |-> line_sig_sel == BCS_SIG_FAULT && !switch_on)
		else $error("over temperature not reported");
	a_pin_fault: assert property (pin_fault [*5] |-> line_sig_sel == BCS_SIG_FAULT && !switch_on)
		else $error("pin fault not reported");
	a_trickle_cause: assert property ($rose(trickle_on) |-> $past(clv_window_low, 3) && $past(bulk_above_upper, 3))
		else $error("trickle started without cause");
	a_trickle_excl: assert property (trickle_on |-> !switch_on && line_sig_sel == BCS_SIG_TRACK)
		else $error("trickle outside open switch");
endmodule

/* sim/bcs_companion.sv */
// Behavioural companion controller reading the signalling current.
// Assumes the selector is a registered level.
`timescale 1ns/1ps
module bcs_companion (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire bcs_pkg::bcs_sig_e line_sig_sel,
	output logic comp_en_r
);
	import bcs_pkg::*;
	// Only the tracked line current lets the companion deliver power.
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			comp_en_r <= 1'h0;
		else
			comp_en_r <= (line_sig_sel == BCS_SIG_TRACK);
endmodule

/* sim/testbench.sv */
// Self-checking bench for the bulk capacitor switch controller.
// Assumes short count parameters so timed phases last a few dozen cycles.
`timescale 1ns/1ps
module testbench;
	import bcs_pkg::*;
	localparam int BO = 40;
	localparam int ST = 20;
	localparam int BL = 10;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [N_IN-1:0] c = '0;
	logic sw, tr, cs, en, awready, wready, bvalid, arready, rvalid;
	bcs_sig_e sig;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [1:0] bresp, rresp;
	int n_fail = 0, n_compared = 0;
	integer seed = 32'hA83A79F0;
	bcs_ctrl #(.BROWNOUT_CYCLES(BO), .SETTLE_CYCLES(ST), .BLANK_CYCLES(BL)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n),
		.bulk_above_upper(c[IN_ABOVE_UPPER]), .bulk_below_lower(c[IN_BELOW_LOWER]),
		.bottom_near_zero(c[IN_BOTTOM_ZERO]), .bulk_brown_in(c[IN_BROWN_IN]),
		.bulk_below_uv(c[IN_BELOW_UV]), .bulk_low_line(c[IN_LOW_LINE]),
		.clv_window_low(c[IN_WIN_LOW]), .clv_window_high(c[IN_WIN_HIGH]),
		.over_temp(c[IN_OVER_TEMP]), .temp_recovered(c[IN_TEMP_OK]),
		.pin_fault(c[IN_PIN_FAULT]), .surge_detect(c[IN_SURGE]),
		.switch_on(sw), .trickle_on(tr), .charge_src_on(cs), .line_sig_sel(sig),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	bcs_companion u_comp (.sys_clk(sys_clk), .rst_n(rst_n), .line_sig_sel(sig), .comp_en_r(en));
	initial
		forever #2.5 sys_clk = ~sys_clk;
	function automatic logic [3:0] exp_run(input logic low);
		return low ? BCS_CHARGE : BCS_RUN_OFF;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic pin(input int b, input logic x);
		@(posedge sys_clk);
		c[b] <= x;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw, da, dw;
		logic [1:0] rs;
		@(posedge sys_clk);
		{da, dw} = 2'h0;
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		while (!(da && dw))
		begin
			@(negedge sys_clk);
			ta = !da && awready;
			tw = !dw && wready;
			@(posedge sys_clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			da = da | ta;
			dw = dw | tw;
		end
		@(negedge sys_clk);
		while (!bvalid) @(negedge sys_clk);
		rs = bresp;
		@(posedge sys_clk);
		bready <= 1'h0;
		chk(rs, r);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		@(negedge sys_clk);
		while (!arready) @(negedge sys_clk);
		@(posedge sys_clk);
		arvalid <= 1'h0;
		@(negedge sys_clk);
		while (!rvalid) @(negedge sys_clk);
		d = rdata;
		chk(rresp, r);
		@(posedge sys_clk);
		rready <= 1'h0;
	endtask
	task complete_run;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		complete_run;
	end
	initial
	begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'h1;
		wt(1);
		chk(sig, BCS_SIG_HOLDOFF);
		chk(sw, 1'h0);
		axr(ADDR_CTRL, v, RESP_OKAY);
		chk(v[0], CTRL_EN_RESET);
		pin(IN_BROWN_IN, 1'h1);
		wt(ST + 10);
		chk(en, 1'h1);
		axr(ADDR_STATUS, v, RESP_OKAY);
		chk(v[3:0], exp_run(1'h0));
		pin(IN_BELOW_LOWER, 1'h1);
		wt(5);
		chk(sw, 1'h0);
		pin(IN_BOTTOM_ZERO, 1'h1);
		wt(5);
		chk(sw, 1'h1);
		pin(IN_SURGE, 1'h1);
		pin(IN_SURGE, 1'h0);
		wt(4);
		chk(sw, 1'h0);
		chk(sig, BCS_SIG_TRACK);
		wt(BL + 6);
		chk(sw, 1'h1);
		pin(IN_BELOW_LOWER, 1'h0);
		pin(IN_ABOVE_UPPER, 1'h1);
		wt(5);
		chk(sw, 1'h0);
		pin(IN_WIN_LOW, 1'h1);
		wt(5);
		chk(tr, 1'h1);
		pin(IN_WIN_LOW, 1'h0);
		pin(IN_WIN_HIGH, 1'h1);
		wt(5);
		chk(tr, 1'h0);
		pin(IN_WIN_HIGH, 1'h0);
		pin(IN_ABOVE_UPPER, 1'h0);
		pin(IN_BELOW_UV, 1'h1);
		wt(BO - 8);
		pin(IN_BELOW_UV, 1'h0);
		pin(IN_BELOW_UV, 1'h1);
		wt(BO - 8);
		chk(sig, BCS_SIG_TRACK);
		wt(15);
		chk(sig, BCS_SIG_HOLDOFF);
		pin(IN_BELOW_UV, 1'h0);
		pin(IN_LOW_LINE, 1'h1);
		wt(ST + 8);
		chk(cs, 1'h1);
		axr(ADDR_STATUS, v, RESP_OKAY);
		chk(v[3:0], exp_run(1'h1));
		pin(IN_WIN_HIGH, 1'h1);
		wt(5);
		chk(cs, 1'h0);
		pin(IN_WIN_HIGH, 1'h0);
		axr(ADDR_EVENTS, v, RESP_OKAY);
		chk(v[3:0], 4'h9);
		axw(ADDR_EVENTS, 32'hF, RESP_OKAY);
		axr(ADDR_EVENTS, v, RESP_OKAY);
		chk(v[3:0], 4'h0);
		pin(IN_OVER_TEMP, 1'h1);
		wt(5);
		chk(sig, BCS_SIG_FAULT);
		pin(IN_OVER_TEMP, 1'h0);
		wt(5);
		chk(sig, BCS_SIG_FAULT);
		pin(IN_TEMP_OK, 1'h1);
		wt(5);
		chk(sig, BCS_SIG_HOLDOFF);
		pin(IN_TEMP_OK, 1'h0);
		pin(IN_PIN_FAULT, 1'h1);
		wt(8);
		chk(sig, BCS_SIG_FAULT);
		pin(IN_PIN_FAULT, 1'h0);
		wt(5);
		chk(sig, BCS_SIG_HOLDOFF);
		axw(8'h0C, $random(seed), RESP_SLVERR);
		axr(8'h10, v, RESP_SLVERR);
		chk(v, 32'h0);
		axw(ADDR_CTRL, 32'h0, RESP_OKAY);
		axr(ADDR_STATUS, v, RESP_OKAY);
		chk(v[3:0], BCS_OFF);
		axw(ADDR_CTRL, 32'h1, RESP_OKAY);
		// A bulk level cannot sit above the upper and below the lower threshold at once.
		repeat (300)
		begin
			@(posedge sys_clk);
			v = $random(seed);
			if (v[IN_ABOVE_UPPER])
			begin
				v[IN_BELOW_LOWER] = 1'h0;
			end
			c <= v[N_IN-1:0] & 12'h8FF;
		end
		wt(5);
		complete_run;
	end
endmodule
bind bcs_ctrl bcs_props u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .bulk_above_upper(bulk_above_upper),
	.bulk_below_lower(bulk_below_lower), .bottom_near_zero(bottom_near_zero),
	.clv_window_low(clv_window_low), .over_temp(over_temp), .pin_fault(pin_fault),
	.surge_detect(surge_detect), .switch_on(switch_on), .trickle_on(trickle_on), .line_sig_sel(line_sig_sel)
);
